/* File: src/buck_fault_map.svh */
// constants of the buck channel fault supervisor
`ifndef BUCK_FAULT_MAP_SVH
`define BUCK_FAULT_MAP_SVH
`define CLK_FREQ_HZ 40000000
`define UV_DELAY_US 30
`define UV_DELAY_CYC ((`CLK_FREQ_HZ / 1000000) * `UV_DELAY_US)
`define UV_CNT_W 11
`define SS_CNT_W 24
`define SS_ARM_NUM 17
`define SS_ARM_DEN 10
`define SS_TIME_CYC_DEF 400000
`define MIN_LS_CYC 4
`define RAMP_STEP_CYC 4
`define PULSE_CNT_W 16
`define FULL_OFF_CYC_DEF 60
`endif

/* File: src/buck_fault_pkg.sv */
// types of the buck channel fault supervisor
package buck_fault_pkg;
    typedef enum logic [2:0] {
        st_off = 3'b000,
        st_high = 3'b001,
        st_low = 3'b011,
        st_wait = 3'b010,
        st_ovlatch = 3'b110,
        st_uvlatch = 3'b111
    } phase_t;
    typedef struct packed {
        logic overvolt;
        logic undervolt;
        logic current_over;
        logic below_ref;
        logic ss_above_fb;
        logic ontime_done;
        logic overtemp;
        logic supply_lockout;
    } sense_t;
    typedef struct packed {
        logic high_side_gate;
        logic low_side_gate;
        logic discharge;
    } drive_t;
endpackage

/* File: src/sense_sync.sv */
// two-stage synchroniser bank for the comparator and fault inputs
`timescale 1ns/1ps
`default_nettype none
module sense_sync
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // raw and synchronised sense
    input wire buck_fault_pkg::sense_t raw_i,
    output var buck_fault_pkg::sense_t sync_o
);
    localparam int W = $bits(buck_fault_pkg::sense_t);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] stage;
    logic [W-1:0] next_stage;
    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_bit
            always_comb
            begin
                next_meta[g] = raw_i[g];
                next_stage[g] = meta[g];
            end
            always_ff @(posedge clk_i)
            begin
                if (reset_i)
                begin
                    meta[g] <= 1'b0;
                    stage[g] <= 1'b0;
                end
                else
                begin
                    meta[g] <= next_meta[g];
                    stage[g] <= next_stage[g];
                end
            end
        end
    endgenerate
    assign sync_o = stage; // see [RQ15]
endmodule
`default_nettype wire

/* File: src/buck_fault_protection_sequencer.sv */
// fault supervisor and gate sequencer for one buck channel
`timescale 1ns/1ps
`default_nettype none
`include "buck_fault_map.svh"
// Overview of operation
// [RQ1] discharge on when disabled or protection off
// [RQ2] low-side gate off during discharge
// [RQ3] valley limit sampled in low phase delays
// [RQ4] overvoltage latches high off, low on
// [RQ5] undervoltage for 30 us latches gates off
// [RQ6] undervoltage ignored until 1.7 soft-start
// [RQ7] latches cleared only by enable low
// [RQ8] supply lockout: gates off, discharge on
// [RQ9] supply lockout recovers automatically
// [RQ10] overtemperature: gates off, discharge on
// [RQ11] overtemperature recovers automatically
// [RQ12] cycle: high until one-shot, restart below ref
// [RQ13] soft start begins on enable rising
// [RQ14] prebias: low held off, then widened
// [RQ15] inputs double-synchronised, delay in cycles
module buck_fault_protection_sequencer
#(
    parameter logic [`SS_CNT_W-1:0] SOFT_START_TIME_CYC = `SS_TIME_CYC_DEF,
    parameter logic [`PULSE_CNT_W-1:0] FULL_OFF_CYC = `FULL_OFF_CYC_DEF
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // channel control, same clock domain
    input wire logic channel_enable_i,
    // asynchronous comparator and fault inputs
    input wire logic overvolt_cmp_i,
    input wire logic undervolt_cmp_i,
    input wire logic valley_current_limit_i,
    input wire logic below_ref_i,
    input wire logic ss_above_fb_i,
    input wire logic ontime_done_i,
    input wire logic overtemp_i,
    input wire logic supply_lockout_i,
    // gate and discharge commands
    output logic high_side_gate_o,
    output logic low_side_gate_o,
    output logic discharge_o,
    // status
    output logic soft_start_active_o,
    output logic overvolt_fault_o,
    output logic undervolt_fault_o
);
    buck_fault_pkg::sense_t raw;
    buck_fault_pkg::sense_t sense;
    buck_fault_pkg::phase_t phase;
    buck_fault_pkg::phase_t next_phase;
    buck_fault_pkg::drive_t drive;
    buck_fault_pkg::drive_t next_drive;
    logic [`UV_CNT_W-1:0] uv_cnt;
    logic [`UV_CNT_W-1:0] next_uv_cnt;
    logic [`SS_CNT_W+1:0] ss_cnt;
    logic [`SS_CNT_W+1:0] next_ss_cnt;
    logic [`PULSE_CNT_W-1:0] ls_cnt;
    logic [`PULSE_CNT_W-1:0] next_ls_cnt;
    logic [`PULSE_CNT_W-1:0] ls_limit;
    logic [`PULSE_CNT_W-1:0] next_ls_limit;
    logic ss_done;
    logic next_ss_done;
    logic uv_armed;
    logic next_uv_armed;
    logic prebias_hold;
    logic next_prebias_hold;
    logic enable_q;
    logic ov_q;
    logic uv_q;
    logic next_ov_q;
    logic next_uv_q;
    logic shutoff;
    logic [`SS_CNT_W+5:0] arm_cyc;

    assign raw = '{
        overvolt: overvolt_cmp_i,
        undervolt: undervolt_cmp_i,
        current_over: valley_current_limit_i,
        below_ref: below_ref_i,
        ss_above_fb: ss_above_fb_i,
        ontime_done: ontime_done_i,
        overtemp: overtemp_i,
        supply_lockout: supply_lockout_i
    };

    // comparators and fault inputs cross two flops before any logic
    sense_sync u_sync // see [RQ15]
    (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .raw_i(raw),
        .sync_o(sense)
    );

    ////////////////////////////////////////////////////////////////////////
    // soft start timing and undervolt arming

    assign arm_cyc = (`SS_CNT_W+6)'((SOFT_START_TIME_CYC * `SS_ARM_NUM)
                     / `SS_ARM_DEN);
    // non-latching conditions, recover on their own
    assign shutoff = sense.supply_lockout || sense.overtemp; // see [RQ9]

    always_comb
    begin
        next_ss_cnt = ss_cnt;
        next_ss_done = ss_done;
        next_uv_armed = uv_armed;
        if (!channel_enable_i || shutoff)
        begin
            // restart soft start after any off period
            next_ss_cnt = '0; // see [RQ13]
            next_ss_done = 1'b0;
            next_uv_armed = 1'b0;
        end
        else
        begin
            // counter parks at the arming point and never wraps
            if (ss_cnt < (`SS_CNT_W+2)'(arm_cyc))
                next_ss_cnt = ss_cnt + 1'b1;
            if (ss_cnt >= (`SS_CNT_W+2)'(SOFT_START_TIME_CYC))
                next_ss_done = 1'b1;
            if (ss_cnt >= (`SS_CNT_W+2)'(arm_cyc))
                next_uv_armed = 1'b1; // see [RQ6]
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            ss_cnt <= '0;
            ss_done <= 1'b0;
            uv_armed <= 1'b0;
            enable_q <= 1'b0;
        end
        else
        begin
            ss_cnt <= next_ss_cnt;
            ss_done <= next_ss_done;
            uv_armed <= next_uv_armed;
            enable_q <= channel_enable_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // latched over and under voltage faults

    always_comb
    begin
        next_ov_q = ov_q;
        next_uv_q = uv_q;
        next_uv_cnt = '0;
        if (!channel_enable_i)
        begin
            next_ov_q = 1'b0; // see [RQ7]
            next_uv_q = 1'b0;
        end
        else
        begin
            // lockout and overtemperature mask the overvoltage set
            if (sense.overvolt && !shutoff)
                next_ov_q = 1'b1; // see [RQ4]
            if (uv_armed && sense.undervolt && !uv_q)
            begin
                next_uv_cnt = uv_cnt + 1'b1; // see [RQ5]
                // delay is a whole number of clock cycles
                if (uv_cnt >= `UV_CNT_W'(`UV_DELAY_CYC - 1)) // see [RQ15]
                    next_uv_q = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            ov_q <= 1'b0;
            uv_q <= 1'b0;
            uv_cnt <= '0;
        end
        else
        begin
            ov_q <= next_ov_q;
            uv_q <= next_uv_q;
            uv_cnt <= next_uv_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // switching cycle and gate sequencing

    always_comb
    begin
        next_phase = phase;
        next_ls_cnt = ls_cnt;
        next_ls_limit = ls_limit;
        next_prebias_hold = prebias_hold;
        if (!channel_enable_i || shutoff)
        begin
            next_phase = buck_fault_pkg::st_off; // see [RQ8]
            next_prebias_hold = 1'b1;
            next_ls_limit = `PULSE_CNT_W'(`MIN_LS_CYC);
        end
        else if (uv_q)
            next_phase = buck_fault_pkg::st_uvlatch; // see [RQ5]
        else if (ov_q)
            next_phase = buck_fault_pkg::st_ovlatch; // see [RQ4]
        else
        begin
            if (prebias_hold && sense.ss_above_fb)
                next_prebias_hold = 1'b0; // see [RQ14]
            case (phase)
                buck_fault_pkg::st_off,
                buck_fault_pkg::st_ovlatch,
                buck_fault_pkg::st_uvlatch:
                    if (sense.below_ref)
                        next_phase = buck_fault_pkg::st_high;
                buck_fault_pkg::st_high:
                    if (sense.ontime_done)
                    begin
                        next_phase = buck_fault_pkg::st_low; // see [RQ12]
                        next_ls_cnt = '0;
                    end
                buck_fault_pkg::st_low:
                begin
                    if (ls_cnt != '1)
                        next_ls_cnt = ls_cnt + 1'b1;
                    // the valley limit only counts while the low gate is on
                    if (sense.current_over && drive.low_side_gate)
                        next_phase = buck_fault_pkg::st_low; // see [RQ3]
                    else if (sense.below_ref)
                    begin
                        next_phase = buck_fault_pkg::st_high; // see [RQ12]
                        if (!prebias_hold && ls_limit < FULL_OFF_CYC)
                            next_ls_limit = ls_limit
                                + `PULSE_CNT_W'(`RAMP_STEP_CYC); // see [RQ14]
                    end
                end
                default:
                    next_phase = buck_fault_pkg::st_off;
            endcase
        end
    end

    always_comb
    begin
        // gate commands follow the phase about to be entered
        next_drive = '0;
        case (next_phase)
            buck_fault_pkg::st_high:
                next_drive.high_side_gate = 1'b1;
            buck_fault_pkg::st_low:
                // pulse width limited during prebias ramp
                next_drive.low_side_gate = !prebias_hold
                    && (next_ls_cnt < ls_limit || ls_limit >= FULL_OFF_CYC);
            buck_fault_pkg::st_ovlatch:
                next_drive.low_side_gate = 1'b1; // see [RQ4]
            buck_fault_pkg::st_uvlatch:
                next_drive.discharge = 1'b1; // see [RQ1]
            default:
                next_drive.discharge = 1'b1; // see [RQ1] [RQ10] [RQ11]
        endcase
        if (next_drive.discharge)
            next_drive.low_side_gate = 1'b0; // see [RQ2]
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            phase <= buck_fault_pkg::st_off;
            drive <= 3'b001;
            ls_cnt <= '0;
            ls_limit <= `PULSE_CNT_W'(`MIN_LS_CYC);
            prebias_hold <= 1'b1;
            high_side_gate_o <= 1'b0;
            low_side_gate_o <= 1'b0;
            discharge_o <= 1'b1;
            soft_start_active_o <= 1'b0;
            overvolt_fault_o <= 1'b0;
            undervolt_fault_o <= 1'b0;
        end
        else
        begin
            phase <= next_phase;
            drive <= next_drive;
            ls_cnt <= next_ls_cnt;
            ls_limit <= next_ls_limit;
            prebias_hold <= next_prebias_hold;
            high_side_gate_o <= next_drive.high_side_gate;
            low_side_gate_o <= next_drive.low_side_gate;
            discharge_o <= next_drive.discharge;
            soft_start_active_o <= enable_q && !next_ss_done;
            // fault flags lead the gate change by one clock
            overvolt_fault_o <= next_ov_q;
            undervolt_fault_o <= next_uv_q;
        end
    end
endmodule
`default_nettype wire

/* File: test/buck_fault_chk.sv */
// assertion checker for the buck fault supervisor
`timescale 1ns/1ps
`default_nettype none
`include "buck_fault_map.svh"
module buck_fault_chk
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // inputs watched
    input wire logic channel_enable_i,
    input wire logic undervolt_cmp_i,
    input wire logic valley_current_limit_i,
    input wire logic overtemp_i,
    input wire logic supply_lockout_i,
    // outputs watched
    input wire logic high_side_gate_o,
    input wire logic low_side_gate_o,
    input wire logic discharge_o,
    input wire logic overvolt_fault_o,
    input wire logic undervolt_fault_o
);
    localparam int UV_CYC = `UV_DELAY_CYC;
    int uv_run;
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    always_ff @(posedge clk_i)
    begin
        uv_run <= (reset_i || !undervolt_cmp_i) ? 0 : uv_run + 1;
    end
    a_off_discharge:
        assert property (!channel_enable_i [*3] |-> discharge_o)
        else $error("discharge off while disabled");
    a_discharge_low_off:
        assert property (discharge_o |-> !low_side_gate_o)
        else $error("low gate on during discharge");
    a_valley_hold:
        assert property (valley_current_limit_i [*4] ##0 low_side_gate_o
            |=> !high_side_gate_o)
        else $error("high gate started over current limit");
    a_ov_gates:
        assert property ($rose(overvolt_fault_o)
            |-> ##[0:1] (low_side_gate_o && !high_side_gate_o))
        else $error("overvolt gate state wrong");
    a_uv_delay:
        assert property ($rose(undervolt_fault_o) |-> uv_run >= UV_CYC)
        else $error("undervolt latched too early");
    a_uv_gates:
        assert property (undervolt_fault_o [*2]
            |-> discharge_o && !high_side_gate_o && !low_side_gate_o)
        else $error("undervolt gate state wrong");
    a_latch_clear:
        assert property ($fell(overvolt_fault_o) || $fell(undervolt_fault_o)
            |-> !channel_enable_i || !$past(channel_enable_i))
        else $error("fault latch cleared while enabled");
    a_lockout_off:
        assert property (supply_lockout_i [*5]
            |-> discharge_o && !high_side_gate_o && !low_side_gate_o)
        else $error("lockout not forcing off");
    a_overtemp_off:
        assert property (overtemp_i [*5]
            |-> discharge_o && !high_side_gate_o && !low_side_gate_o)
        else $error("overtemp not forcing off");
endmodule
bind buck_fault_protection_sequencer buck_fault_chk i_chk
(
    .clk_i(clk_i),
    .reset_i(reset_i),
    .channel_enable_i(channel_enable_i),
    .undervolt_cmp_i(undervolt_cmp_i),
    .valley_current_limit_i(valley_current_limit_i),
    .overtemp_i(overtemp_i),
    .supply_lockout_i(supply_lockout_i),
    .high_side_gate_o(high_side_gate_o),
    .low_side_gate_o(low_side_gate_o),
    .discharge_o(discharge_o),
    .overvolt_fault_o(overvolt_fault_o),
    .undervolt_fault_o(undervolt_fault_o)
);
`default_nettype wire

/* File: test/power_stage_model.sv */
// behavioural power stage, one-shot and feedback of one channel
`timescale 1ns/1ps
`default_nettype none
module power_stage_model
#(
    parameter int ON_CYC = 6,
    parameter int OFF_CYC = 10
)
(
    // clock
    input wire logic clk_i,
    // gate command
    input wire logic high_side_gate_i,
    // comparator results
    output logic ontime_done_o,
    output logic below_ref_o
);
    int on_cnt = 0;
    int off_cnt = 0;
    always @(negedge clk_i)
    begin
        on_cnt <= high_side_gate_i ? on_cnt + 1 : 0;
        off_cnt <= high_side_gate_i ? 0 : off_cnt + 1;
    end
    // output sags below reference some time after the pulse
    assign ontime_done_o = on_cnt >= ON_CYC;
    assign below_ref_o = off_cnt >= OFF_CYC;
endmodule
`default_nettype wire

/* File: test/tb.sv */
// self-checking bench for the buck fault supervisor
`timescale 1ns/1ps
`default_nettype none
`include "buck_fault_map.svh"
module tb;
    localparam int ARM = 100 * `SS_ARM_NUM / `SS_ARM_DEN;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic enable = 1'b0;
    buck_fault_pkg::sense_t sense = '0;
    logic hs, ls, dis, ss_act, ov_f, uv_f, on_done, below;
    logic [3:0] flags;
    int num_errors = 0;
    int samples_checked = 0;
    assign flags = {uv_f, ov_f, ls, hs};
    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end
    buck_fault_protection_sequencer #(.SOFT_START_TIME_CYC(24'h000064))
    i_dut (.clk_i(clk_i), .reset_i(reset_i), .channel_enable_i(enable),
        .overvolt_cmp_i(sense.overvolt), .undervolt_cmp_i(sense.undervolt),
        .valley_current_limit_i(sense.current_over), .below_ref_i(below),
        .ss_above_fb_i(sense.ss_above_fb), .ontime_done_i(on_done),
        .overtemp_i(sense.overtemp), .supply_lockout_i(sense.supply_lockout),
        .high_side_gate_o(hs), .low_side_gate_o(ls), .discharge_o(dis),
        .soft_start_active_o(ss_act), .overvolt_fault_o(ov_f),
        .undervolt_fault_o(uv_f));
    power_stage_model i_stage (.clk_i(clk_i), .high_side_gate_i(hs),
        .ontime_done_o(on_done), .below_ref_o(below));
    task automatic stop_test();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic fail(string msg);
        $display("mismatch at %0t: %s", $time, msg);
        num_errors++;
    endtask
    task automatic chk_drive(logic [2:0] exp, string msg);
        samples_checked++;
        if ({hs, ls, dis} !== exp)
            fail(msg);
    endtask
    task automatic chk_bit(logic act, logic exp, string msg);
        samples_checked++;
        if (act !== exp)
            fail(msg);
    endtask
    task automatic cycles(int n);
        repeat (n) @(negedge clk_i);
    endtask
    // bounded wait on a gate or fault flag
    task automatic wait_for(int sel, logic val, int max);
        for (int i = 0; i < max; i++)
        begin
            if (flags[sel] === val)
                return;
            @(negedge clk_i);
        end
        fail("wait ran out");
        stop_test();
    endtask
    initial
    begin
        cycles(10);
        reset_i = 1'b0;
        chk_drive(3'b001, "reset drive");
        enable = 1'b1;
        wait_for(0, 1'b1, 40);
        chk_bit(ss_act, 1'b1, "soft start not active");
        chk_bit(dis, 1'b0, "discharge while on");
        wait_for(0, 1'b0, 40);
        cycles(8);
        chk_bit(ls, 1'b0, "low gate while prebiased");
        sense.ss_above_fb = 1'b1;
        wait_for(1, 1'b1, 200);
        wait_for(0, 1'b1, 200);
        $display("test start done");
        cycles(800);
        chk_bit(ss_act, 1'b0, "soft start stuck");
        wait_for(0, 1'b1, 100);
        wait_for(1, 1'b1, 100);
        sense.current_over = 1'b1;
        cycles(40);
        chk_drive(3'b010, "valley hold");
        sense.current_over = 1'b0;
        wait_for(0, 1'b1, 40);
        $display("test valley done");
        for (int k = 0; k < 2; k++)
        begin
            sense.supply_lockout = (k == 0);
            sense.overtemp = (k == 1);
            cycles(4);
            chk_drive(3'b001, "forced off");
            sense.supply_lockout = 1'b0;
            sense.overtemp = 1'b0;
            wait_for(0, 1'b1, 400);
        end
        $display("test lockout done");
        sense.overvolt = 1'b1;
        wait_for(2, 1'b1, 10);
        cycles(1);
        chk_drive(3'b010, "overvolt drive");
        sense.overvolt = 1'b0;
        cycles(20);
        chk_bit(ov_f, 1'b1, "overvolt held");
        enable = 1'b0;
        cycles(3);
        chk_bit(ov_f, 1'b0, "overvolt cleared");
        chk_drive(3'b001, "disabled drive");
        $display("test overvolt done");
        enable = 1'b1;
        cycles(ARM + 10);
        sense.undervolt = 1'b1;
        cycles(`UV_DELAY_CYC - 5);
        chk_bit(uv_f, 1'b0, "undervolt early");
        wait_for(3, 1'b1, 20);
        cycles(1);
        chk_drive(3'b001, "undervolt drive");
        sense.undervolt = 1'b0;
        cycles(5);
        chk_bit(uv_f, 1'b1, "undervolt held");
        enable = 1'b0;
        cycles(3);
        chk_bit(uv_f, 1'b0, "undervolt cleared");
        enable = 1'b1;
        sense.undervolt = 1'b1;
        cycles(ARM + `UV_DELAY_CYC - 10);
        chk_bit(uv_f, 1'b0, "undervolt not masked");
        wait_for(3, 1'b1, 30);
        $display("test undervolt done");
        stop_test();
    end
endmodule
`default_nettype wire
